// File: inc/halt_wakeup_pkg.sv
package halt_wakeup_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] WAKE_EN_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] PORTA_DATA_OFS = 8'h0C;
    localparam logic [7:0] PORTA_DIR_OFS = 8'h10;
    localparam logic [7:0] TIMER0_CTRL_OFS = 8'h14;
    localparam logic [7:0] TIMER1_CTRL_OFS = 8'h18;

    // Control register fields
    localparam int CTRL_LCD_ON_HALT_BIT = 0;
    localparam int CTRL_IRC_CLOCK_CTRL_BIT = 1;
    localparam int CTRL_WDT_SRC_IRC_BIT = 2;
    localparam int CTRL_IRC_SEL_BIT = 3;
    localparam int CTRL_WIDTH = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // Status register fields
    localparam int STATUS_TIMEOUT_BIT = 0;
    localparam int STATUS_POWERDOWN_BIT = 1;
    localparam int STATUS_HALTED_BIT = 2;
    localparam int STATUS_DELAY_BIT = 3;

    // Reset values
    localparam logic [7:0] WAKE_EN_RESET = 8'h00;
    localparam logic [7:0] PORT_RESET = 8'hFF;
    localparam logic [7:0] TIMER_CTRL_RESET = 8'h08;
    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    // Start-up delay in system clock periods
    localparam int STARTUP_CYCLES = 1024;
    localparam int STARTUP_CNT_W = 11;
    localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_CYCLES - 1);

    // Port A width and interrupt source count
    localparam int PORTA_W = 8;
    localparam int INT_SRC_W = 4;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HALT,
        ST_DELAY,
        ST_ACK
    } power_state_t;

    typedef enum logic [1:0] {
        WAKE_NONE,
        WAKE_NEXT,
        WAKE_INT
    } wake_kind_t;

endpackage

// File: hw/halt_wakeup_reset_control.sv
// The implementer's own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// - Halt stops system osc, RC keeps running only if IRC select bit set
// - Halt preserves registers and port states
// - Halt clears watchdog when RC-clocked
// - Halt sets powerdown, clears timeout flag
// - LCD runs in halt if enabled and IRC clock control bit clear
// - Four wake sources leave halt
// - Pin reset full; watchdog-in-halt warm reset
// - Powerdown cleared by powerup, clear-watchdog
// - Timeout flag set on watchdog overflow
// - Per-pin port A wake enable
// - Pin wake resumes at next instruction
// - Interrupt wake: ack or next instruction
// - Already-pending interrupt cannot wake
// - 1024-cycle dummy period after wake
// - Next instruction right after dummy period
// - Flag pair encodes reset cause
// - Start-up delay at power-up and wake
// - Chip reset clears core state
// - Non-warm reset loads port, timer values
module halt_wakeup_reset_control
    import halt_wakeup_pkg::*;
(
    // Clock and power-up reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Pins
    input wire logic external_reset_pin_n_i,
    input wire logic [PORTA_W-1:0] porta_pin_i,
    // Core events
    input wire logic halt_exec_i,
    input wire logic clr_wdt_i,
    input wire logic wdt_overflow_i,
    input wire logic [INT_SRC_W-1:0] int_req_i,
    input wire logic [INT_SRC_W-1:0] int_en_i,
    input wire logic stack_full_i,
    // Clock and watchdog control
    output logic sys_osc_en_o,
    output logic irc_osc_en_o,
    output logic lcd_run_o,
    output logic wdt_clear_o,
    // Core sequencing
    output logic core_hold_o,
    output logic chip_reset_o,
    output logic warm_reset_o,
    output logic resume_next_o,
    output logic int_ack_o,
    // Status flags
    output logic powerdown_flag_o,
    output logic timeout_flag_o,
    // Reset-loaded registers
    output logic [7:0] porta_data_reg_o,
    output logic [7:0] porta_dir_reg_o,
    output logic [7:0] timer0_ctrl_reg_o,
    output logic [7:0] timer1_ctrl_reg_o
);

    power_state_t state;
    wake_kind_t wake_kind;
    logic [CTRL_WIDTH-1:0] ctrl;
    logic [PORTA_W-1:0] wake_en;
    logic [STARTUP_CNT_W-1:0] delay_cnt;
    logic [INT_SRC_W-1:0] int_at_halt;
    logic rst_pin_s1;
    logic rst_pin_s2;
    logic [PORTA_W-1:0] pa_s1;
    logic [PORTA_W-1:0] pa_s2;
    logic [PORTA_W-1:0] pa_d;
    logic pin_reset;
    logic pin_wake;
    logic int_wake;
    logic enter_halt;
    logic halted;
    logic delay_done;
    logic release_next;
    logic release_ack;
    logic next_hold;
    logic full_reset;
    logic wdt_run_reset;
    logic wdt_warm;
    logic bus_req;
    logic bus_wr;
    logic [31:0] next_dat;

    // Pin synchronisers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_pin_s1 <= 1'b1;
            rst_pin_s2 <= 1'b1;
            pa_s1 <= PORT_RESET;
            pa_s2 <= PORT_RESET;
            pa_d <= PORT_RESET;
        end else begin
            rst_pin_s1 <= external_reset_pin_n_i;
            rst_pin_s2 <= rst_pin_s1;
            pa_s1 <= porta_pin_i;
            pa_s2 <= pa_s1;
            pa_d <= pa_s2;
        end
    end

    // Event decode
    always_comb begin
        halted = (state == ST_HALT);
        pin_reset = ~rst_pin_s2;
        pin_wake = |(pa_d & ~pa_s2 & wake_en);
        int_wake = |(int_req_i & ~int_at_halt);
        enter_halt = halt_exec_i & (state == ST_RUN) & ~pin_reset;
        delay_done = (delay_cnt == STARTUP_LAST);
        wdt_run_reset = wdt_overflow_i & (state == ST_RUN) & ~pin_reset;
        wdt_warm = wdt_overflow_i & halted & ~pin_reset;
        full_reset = pin_reset | wdt_run_reset;
        release_next = (state == ST_DELAY) & delay_done & (wake_kind != WAKE_INT);
        release_ack = (state == ST_ACK);
        next_hold = ~((state == ST_RUN) & ~enter_halt) & ~release_next & ~release_ack;
    end

    // Power state sequencing
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_DELAY;
            wake_kind <= WAKE_NONE;
        end else if (pin_reset) begin
            if (halted) begin
                state <= ST_DELAY;
            end
            wake_kind <= WAKE_NONE;
        end else begin
            case (state)
                ST_RUN: begin
                    if (enter_halt) begin
                        state <= ST_HALT;
                    end
                end
                ST_HALT: begin
                    if (wdt_warm) begin
                        state <= ST_DELAY;
                        wake_kind <= WAKE_NONE;
                    end else if (pin_wake) begin
                        state <= ST_DELAY;
                        wake_kind <= WAKE_NEXT;
                    end else if (int_wake) begin
                        state <= ST_DELAY;
                        if (|(int_req_i & ~int_at_halt & int_en_i) & ~stack_full_i) begin
                            wake_kind <= WAKE_INT;
                        end else begin
                            wake_kind <= WAKE_NEXT;
                        end
                    end
                end
                ST_DELAY: begin
                    if (delay_done) begin
                        state <= (wake_kind == WAKE_INT) ? ST_ACK : ST_RUN;
                    end
                end
                ST_ACK: begin
                    state <= ST_RUN;
                    wake_kind <= WAKE_NONE;
                end
                default: begin
                    state <= ST_RUN;
                end
            endcase
        end
    end

    // Start-up delay counter
    always_ff @(posedge clk_i) begin
        if (rst_i || pin_reset || state != ST_DELAY) begin
            delay_cnt <= '0;
        end else if (!delay_done) begin
            delay_cnt <= delay_cnt + 1'b1;
        end
    end

    // Pending interrupts at halt entry
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            int_at_halt <= '0;
        end else if (enter_halt) begin
            int_at_halt <= int_req_i;
        end else if (halted) begin
            int_at_halt <= int_at_halt & int_req_i;
        end
    end

    // Reset-cause flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            powerdown_flag_o <= 1'b0;
        end else if (enter_halt) begin
            powerdown_flag_o <= 1'b1;
        end else if (clr_wdt_i && state == ST_RUN) begin
            powerdown_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timeout_flag_o <= 1'b0;
        end else if (wdt_overflow_i && !pin_reset) begin
            timeout_flag_o <= 1'b1;
        end else if (enter_halt || (pin_reset && halted)) begin
            timeout_flag_o <= 1'b0;
        end
    end

    // Clock, LCD and watchdog control
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_osc_en_o <= 1'b1;
            irc_osc_en_o <= 1'b1;
            lcd_run_o <= 1'b1;
            wdt_clear_o <= 1'b1;
        end else begin
            sys_osc_en_o <= ~(halted | enter_halt) | pin_reset;
            irc_osc_en_o <= ~(halted | enter_halt) | ctrl[CTRL_IRC_SEL_BIT];
            lcd_run_o <= ~(halted | enter_halt)
                | (~ctrl[CTRL_IRC_CLOCK_CTRL_BIT] & ctrl[CTRL_LCD_ON_HALT_BIT]);
            wdt_clear_o <= full_reset
                | (enter_halt & ctrl[CTRL_WDT_SRC_IRC_BIT]);
        end
    end

    // Core sequencing outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_hold_o <= 1'b1;
            chip_reset_o <= 1'b1;
            warm_reset_o <= 1'b0;
            resume_next_o <= 1'b0;
            int_ack_o <= 1'b0;
        end else begin
            core_hold_o <= next_hold | pin_reset;
            chip_reset_o <= full_reset;
            warm_reset_o <= wdt_warm;
            resume_next_o <= release_next & (wake_kind == WAKE_NEXT)
                & ~pin_reset;
            int_ack_o <= (state == ST_DELAY) & delay_done
                & (wake_kind == WAKE_INT) & ~pin_reset;
        end
    end

    // Wishbone access
    always_comb begin
        bus_req = cyc_i & stb_i & ~ack_o;
        bus_wr = cyc_i & stb_i & ack_o & we_i & sel_i[0] & ~halted;
        case (adr_i)
            CTRL_OFS: next_dat = {28'h000_0000, ctrl};
            WAKE_EN_OFS: next_dat = {24'h00_0000, wake_en};
            STATUS_OFS: next_dat = {28'h000_0000, (state == ST_DELAY), halted,
                powerdown_flag_o, timeout_flag_o};
            PORTA_DATA_OFS: next_dat = {24'h00_0000, porta_data_reg_o};
            PORTA_DIR_OFS: next_dat = {24'h00_0000, porta_dir_reg_o};
            TIMER0_CTRL_OFS: next_dat = {24'h00_0000, timer0_ctrl_reg_o};
            TIMER1_CTRL_OFS: next_dat = {24'h00_0000, timer1_ctrl_reg_o};
            default: next_dat = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= UNMAPPED_READ;
        end else begin
            ack_o <= bus_req;
            dat_o <= (bus_req & ~we_i) ? next_dat : UNMAPPED_READ;
        end
    end

    // Configuration registers survive every reset but power-up
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RESET;
            wake_en <= WAKE_EN_RESET;
        end else if (bus_wr) begin
            if (adr_i == CTRL_OFS) begin
                ctrl <= dat_i[CTRL_WIDTH-1:0];
            end
            if (adr_i == WAKE_EN_OFS) begin
                wake_en <= dat_i[7:0];
            end
        end
    end

    // Port and timer control registers
    always_ff @(posedge clk_i) begin
        if (rst_i || full_reset) begin
            porta_data_reg_o <= PORT_RESET;
            porta_dir_reg_o <= PORT_RESET;
            timer0_ctrl_reg_o <= TIMER_CTRL_RESET;
            timer1_ctrl_reg_o <= TIMER_CTRL_RESET;
        end else if (bus_wr) begin
            if (adr_i == PORTA_DATA_OFS) begin
                porta_data_reg_o <= dat_i[7:0];
            end
            if (adr_i == PORTA_DIR_OFS) begin
                porta_dir_reg_o <= dat_i[7:0];
            end
            if (adr_i == TIMER0_CTRL_OFS) begin
                timer0_ctrl_reg_o <= dat_i[7:0];
            end
            if (adr_i == TIMER1_CTRL_OFS) begin
                timer1_ctrl_reg_o <= dat_i[7:0];
            end
        end
    end

endmodule // halt_wakeup_reset_control

// File: tb/halt_wakeup_reset_control_checker.sv
`timescale 1ns/10ps
module halt_wakeup_reset_control_checker
    import halt_wakeup_pkg::*;
(
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    // Pins and core events
    input wire logic external_reset_pin_n_i,
    input wire logic halt_exec_i,
    input wire logic wdt_overflow_i,
    // Watched outputs
    input wire logic sys_osc_en_o,
    input wire logic core_hold_o,
    input wire logic chip_reset_o,
    input wire logic warm_reset_o,
    input wire logic resume_next_o,
    input wire logic int_ack_o,
    input wire logic powerdown_flag_o,
    input wire logic timeout_flag_o,
    input wire logic [7:0] porta_data_reg_o,
    input wire logic [7:0] timer0_ctrl_reg_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [10:0] hold_cnt;
    // Cycles stalled with the oscillator running
    always_ff @(posedge clk_i) begin
        if (rst_i || !core_hold_o || !sys_osc_en_o || chip_reset_o) begin
            hold_cnt <= 11'h000;
        end else if (hold_cnt != 11'h7FF) begin
            hold_cnt <= hold_cnt + 11'h001;
        end
    end
    sequence halt_taken;
        halt_exec_i && !core_hold_o && !wdt_overflow_i && external_reset_pin_n_i;
    endsequence
    sequence ack_then_run;
        core_hold_o ##1 !core_hold_o;
    endsequence
    bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not acknowledged");
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    halt_entry_a: assert property (halt_taken |-> ##[1:2] (!sys_osc_en_o && powerdown_flag_o && !timeout_flag_o))
        else $error("halt entry outputs wrong");
    warm_flags_a: assert property (warm_reset_o |-> $stable(porta_data_reg_o) ##1 (timeout_flag_o && powerdown_flag_o && $stable(timer0_ctrl_reg_o)))
        else $error("warm reset flags or registers wrong");
    resume_gap_a: assert property (resume_next_o |-> !core_hold_o && hold_cnt >= 11'h3FE && hold_cnt <= 11'h403)
        else $error("dummy period length wrong");
    int_ack_a: assert property (int_ack_o |-> !resume_next_o ##0 ack_then_run)
        else $error("interrupt ack release wrong");
    pin_reset_a: assert property (!external_reset_pin_n_i [*5] |-> chip_reset_o && core_hold_o)
        else $error("pin reset not applied");
    reload_regs_a: assert property ($fell(chip_reset_o) |-> porta_data_reg_o == PORT_RESET && timer0_ctrl_reg_o == TIMER_CTRL_RESET)
        else $error("registers not reloaded");
    timeout_set_a: assert property (wdt_overflow_i |=> ##[0:1] timeout_flag_o)
        else $error("timeout flag not set");
endmodule // halt_wakeup_reset_control_checker

bind halt_wakeup_reset_control halt_wakeup_reset_control_checker i_halt_wakeup_reset_control_checker (.*);

// File: tb/halt_wakeup_pins_model.sv
`timescale 1ns/10ps
module halt_wakeup_pins_model (
    // Clock
    input wire logic clk_i,
    // Pins, idle high as with pull-ups
    output logic external_reset_pin_n_o,
    output logic [7:0] porta_pin_o
);
    initial begin
        external_reset_pin_n_o = 1'b1;
        porta_pin_o = 8'hFF;
    end
    task automatic press_reset(input int cycles);
        external_reset_pin_n_o <= 1'b0;
        repeat (cycles) @(posedge clk_i);
        external_reset_pin_n_o <= 1'b1;
    endtask
    task automatic pull_low(input logic [7:0] mask, input int cycles);
        porta_pin_o <= ~mask;
        repeat (cycles) @(posedge clk_i);
        porta_pin_o <= 8'hFF;
    endtask
endmodule // halt_wakeup_pins_model

// File: tb/halt_wakeup_reset_control_bench.sv
`timescale 1ns/10ps
module halt_wakeup_reset_control_bench
    import halt_wakeup_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, halt_exec_i = 1'b0, clr_wdt_i = 1'b0;
    logic wdt_overflow_i = 1'b0, stack_full_i = 1'b0, external_reset_pin_n_i;
    logic [7:0] adr_i = 8'h00, porta_pin_i;
    logic [3:0] sel_i = 4'hF, int_req_i = 4'h0, int_en_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000, dat_o;
    logic ack_o, sys_osc_en_o, irc_osc_en_o, lcd_run_o, wdt_clear_o, core_hold_o, chip_reset_o;
    logic warm_reset_o, resume_next_o, int_ack_o, powerdown_flag_o, timeout_flag_o, clrs;
    logic [7:0] porta_data_reg_o, porta_dir_reg_o, timer0_ctrl_reg_o, timer1_ctrl_reg_o;
    logic [2:0] seen;
    int n_errors = 0;
    int checked = 0;
    logic [7:0] ra [7] = '{PORTA_DATA_OFS, PORTA_DIR_OFS, TIMER0_CTRL_OFS, TIMER1_CTRL_OFS,
        STATUS_OFS, CTRL_OFS, 8'h1C};
    logic [7:0] rv [7] = '{8'hFF, 8'hFF, 8'h08, 8'h08, 8'h00, 8'h00, 8'h00};

    always #25 clk_i = ~clk_i;

    halt_wakeup_reset_control i_halt_wakeup_reset_control (.*);
    halt_wakeup_pins_model i_halt_wakeup_pins_model (
        .clk_i(clk_i),
        .external_reset_pin_n_o(external_reset_pin_n_i),
        .porta_pin_o(porta_pin_i)
    );

    task automatic end_of_test;
        $display("checked=%0d n_errors=%0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Wishbone cycle; a read compares against d
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        chk(ack_o, 1'b1);
        if (!w)
            chk(dat_o, d);
        if (ack_o !== 1'b1)
            end_of_test;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Wait for the core to run again, noting pulses seen
    task automatic settle;
        int n;
        n = 0;
        seen = 3'b000;
        do begin
            @(posedge clk_i);
            n++;
            seen |= {warm_reset_o, int_ack_o, resume_next_o};
        end while (core_hold_o !== 1'b0 && n < 2000);
        chk(n >= 1020 && n <= 1036, 1'b1);
        if (n == 2000)
            end_of_test;
    endtask

    task automatic halt(input logic [7:0] c);
        wb(1'b1, CTRL_OFS, {24'h00_0000, c});
        halt_exec_i <= 1'b1;
        @(posedge clk_i);
        halt_exec_i <= 1'b0;
        clrs = 1'b0;
        repeat (3) begin
            @(posedge clk_i);
            clrs |= wdt_clear_o;
        end
    endtask

    task automatic wdt_tick(input logic ov);
        wdt_overflow_i <= ov;
        clr_wdt_i <= !ov;
        @(posedge clk_i);
        wdt_overflow_i <= 1'b0;
        clr_wdt_i <= 1'b0;
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        settle;
        for (int k = 0; k < 7; k++) begin
            wb(1'b0, ra[k], {24'h00_0000, rv[k]});
        end
        $display("reset test done");
        wb(1'b1, WAKE_EN_OFS, 32'h0000_0001);
        wb(1'b1, PORTA_DIR_OFS, 32'h0000_00F0);
        wb(1'b1, PORTA_DATA_OFS, 32'h0000_005A);
        wb(1'b1, TIMER0_CTRL_OFS, 32'h0000_0033);
        wb(1'b1, TIMER1_CTRL_OFS, 32'h0000_0044);
        halt(8'h05);
        chk({sys_osc_en_o, irc_osc_en_o, lcd_run_o, clrs}, 4'b0011);
        wb(1'b0, STATUS_OFS, 32'h0000_0006);
        chk(porta_data_reg_o, 8'h5A);
        i_halt_wakeup_pins_model.pull_low(8'h02, 2);
        repeat (8) @(posedge clk_i);
        wb(1'b0, STATUS_OFS, 32'h0000_0006);
        i_halt_wakeup_pins_model.pull_low(8'h01, 2);
        settle;
        chk(seen, 3'b001);
        $display("port wake test done");
        for (int k = 0; k < 3; k++) begin
            int_en_i <= (k == 1) ? 4'h0 : 4'hF;
            stack_full_i <= (k == 2);
            int_req_i <= 4'h2;
            halt(8'h00);
            repeat (20) @(posedge clk_i);
            wb(1'b0, STATUS_OFS, 32'h0000_0006);
            int_req_i <= 4'h6;
            settle;
            chk(seen, (k == 0) ? 3'b010 : 3'b001);
        end
        $display("interrupt wake test done");
        halt(8'h0A);
        chk({sys_osc_en_o, irc_osc_en_o, lcd_run_o, clrs}, 4'b0100);
        wdt_tick(1'b1);
        settle;
        chk(seen, 3'b100);
        wb(1'b0, STATUS_OFS, 32'h0000_0003);
        chk({porta_data_reg_o, timer0_ctrl_reg_o}, 16'h5A33);
        chk(timer1_ctrl_reg_o, 8'h44);
        wdt_tick(1'b0);
        wb(1'b0, STATUS_OFS, 32'h0000_0001);
        wdt_tick(1'b1);
        wb(1'b0, STATUS_OFS, 32'h0000_0001);
        chk({porta_data_reg_o, porta_dir_reg_o}, 16'hFFFF);
        chk({timer0_ctrl_reg_o, timer1_ctrl_reg_o}, 16'h0808);
        $display("watchdog test done");
        wb(1'b1, PORTA_DATA_OFS, 32'h0000_005A);
        halt(8'h00);
        i_halt_wakeup_pins_model.press_reset(6);
        settle;
        chk(seen, 3'b000);
        wb(1'b0, STATUS_OFS, 32'h0000_0002);
        chk(porta_data_reg_o, 8'hFF);
        i_halt_wakeup_pins_model.press_reset(6);
        repeat (6) @(posedge clk_i);
        wb(1'b0, STATUS_OFS, 32'h0000_0002);
        $display("pin reset test done");
        end_of_test;
    end
endmodule // halt_wakeup_reset_control_bench
